/* File: rtl/dbgbf_debug_regs.v */
`timescale 1ns/1ps
`include "dbgbf_map.vh"
module dbgbf_debug_regs (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // cpu memory bus, application side
  input wire [15:0] cpu_addr_in,
  input wire cpu_rd_in,
  input wire cpu_wr_in,
  input wire [7:0] cpu_wdata_in,
  output wire [7:0] cpu_rdata_out,
  // cpu fetch tracking
  input wire cpu_fetch_in,
  input wire cpu_opcode_in,
  // serial background command port
  input wire bg_cmd_valid_in,
  input wire [2:0] bg_cmd_in,
  input wire [15:0] bg_addr_in,
  input wire [15:0] bg_wdata_in,
  output wire [15:0] bg_rdata_out,
  output wire bg_ack_out,
  // trace logic side
  input wire trace_push_in,
  input wire [15:0] trace_data_in,
  input wire event_only_mode_in,
  input wire run_done_in,
  // results
  output wire [15:0] cmp_a_value_out,
  output wire [15:0] cmp_b_value_out,
  output wire run_flag_out,
  output wire fifo_full_out,
  output wire bkpt_force_req_out,
  output wire bkpt_tag_out,
  output wire mcu_reset_req_out
);
  // ****************************************
  // state
  // ****************************************
  reg [15:0] bkpt_addr_r;
  reg [7:0] bg_status_r;
  reg [7:0] cmp_a_high_r;
  reg [7:0] cmp_a_low_r;
  reg [7:0] cmp_b_high_r;
  reg [7:0] cmp_b_low_r;
  reg run_flag_r;
  reg [15:0] last_opcode_r;
  reg [7:0] cpu_rdata_r;
  reg [15:0] bg_rdata_r;
  reg bg_ack_r;
  reg force_req_r;
  reg tag_r;
  reg reset_req_r;
  wire [15:0] fifo_head;

  // ****************************************
  // decode helpers
  // ****************************************
  // byte seen at an address; reserved and unmapped bytes read zero
  function [7:0] rd_byte;
    input [15:0] adr;
    begin
      if (adr == `DBGBF_ADR_FORCE_RESET) begin
        rd_byte = `DBGBF_RST_BYTE;
      end else if (adr == `DBGBF_ADR_CMP_A_HIGH) begin
        rd_byte = cmp_a_high_r;
      end else if (adr == `DBGBF_ADR_CMP_A_LOW) begin
        rd_byte = cmp_a_low_r;
      end else if (adr == `DBGBF_ADR_CMP_B_HIGH) begin
        rd_byte = cmp_b_high_r;
      end else if (adr == `DBGBF_ADR_CMP_B_LOW) begin
        rd_byte = cmp_b_low_r;
      end else if (adr == `DBGBF_ADR_FIFO_HIGH) begin
        rd_byte = event_only_mode_in ? `DBGBF_RST_BYTE : fifo_head[15:8];
      end else if (adr == `DBGBF_ADR_FIFO_LOW) begin
        rd_byte = fifo_head[7:0];
      end else if (adr == `DBGBF_ADR_RUN_CTRL) begin
        rd_byte = {1'b0, run_flag_r, 6'h00};
      end else begin
        rd_byte = `DBGBF_RST_BYTE;
      end
    end
  endfunction

  // address belongs to a comparator value byte
  function is_cmp;
    input [15:0] adr;
    begin
      is_cmp = (adr >= `DBGBF_ADR_CMP_A_HIGH) && (adr <= `DBGBF_ADR_CMP_B_LOW);
    end
  endfunction

  // background command of the given kind present this cycle
  function bg_cmd_is;
    input [2:0] kind;
    begin
      bg_cmd_is = bg_cmd_valid_in && (bg_cmd_in == kind);
    end
  endfunction

  // ****************************************
  // access strobes
  // ****************************************
  // background memory commands act like cpu accesses, with extra reach
  wire bg_rd_byte = bg_cmd_is(`DBGBF_CMD_READ_BYTE);
  wire bg_wr_byte = bg_cmd_is(`DBGBF_CMD_WRITE_BYTE);
  wire bg_rd_bkpt = bg_cmd_is(`DBGBF_CMD_READ_BREAK);
  wire bg_wr_bkpt = bg_cmd_is(`DBGBF_CMD_WRITE_BREAK);
  wire bg_rd_stat = bg_cmd_is(`DBGBF_CMD_READ_STATUS);
  wire bg_wr_ctrl = bg_cmd_is(`DBGBF_CMD_WRITE_CONTROL);
  // status and breakpoint reads never pass through the memory map decode
  // background wins a same-cycle collision; the cpu is normally halted then
  wire wr_any = bg_wr_byte || cpu_wr_in;
  wire [15:0] wr_addr = bg_wr_byte ? bg_addr_in : cpu_addr_in;
  wire [7:0] wr_data = bg_wr_byte ? bg_wdata_in[7:0] : cpu_wdata_in;
  wire fifo_low_rd = (cpu_rd_in && (cpu_addr_in == `DBGBF_ADR_FIFO_LOW)) ||
                     (bg_rd_byte && (bg_addr_in == `DBGBF_ADR_FIFO_LOW));
  // reads while run-enabled leave the fifo in place
  wire fifo_advance = fifo_low_rd && !run_flag_r;
  wire cmp_wr_ok = wr_any && is_cmp(wr_addr) && !run_flag_r;

  // ****************************************
  // comparator value bytes
  // ****************************************
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      cmp_a_high_r <= `DBGBF_RST_BYTE;
      cmp_a_low_r <= `DBGBF_RST_BYTE;
      cmp_b_high_r <= `DBGBF_RST_BYTE;
      cmp_b_low_r <= `DBGBF_RST_BYTE;
    end else if (cmp_wr_ok) begin
      if (wr_addr == `DBGBF_ADR_CMP_A_HIGH) begin
        cmp_a_high_r <= wr_data;
      end else if (wr_addr == `DBGBF_ADR_CMP_A_LOW) begin
        cmp_a_low_r <= wr_data;
      end else if (wr_addr == `DBGBF_ADR_CMP_B_HIGH) begin
        cmp_b_high_r <= wr_data;
      end else begin
        cmp_b_low_r <= wr_data;
      end
    end
  end

  assign cmp_a_value_out = {cmp_a_high_r, cmp_a_low_r};
  assign cmp_b_value_out = {cmp_b_high_r, cmp_b_low_r};

  // ****************************************
  // run flag
  // ****************************************
  // a write sets or clears it; run completion clears it, a same-cycle set wins
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      run_flag_r <= 1'b0;
    end else if (wr_any && (wr_addr == `DBGBF_ADR_RUN_CTRL)) begin
      run_flag_r <= wr_data[`DBGBF_BIT_RUN_FLAG];
    end else if (run_done_in) begin
      run_flag_r <= 1'b0;
    end
  end
  assign run_flag_out = run_flag_r;

  // ****************************************
  // background-only registers
  // ****************************************
  // not in the memory map, so no cpu write can reach them
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      bkpt_addr_r <= `DBGBF_RST_WORD;
      bg_status_r <= `DBGBF_RST_BG_STATUS;
    end else begin
      if (bg_wr_bkpt) begin
        bkpt_addr_r <= bg_wdata_in;
      end
      if (bg_wr_ctrl) begin
        bg_status_r <= bg_wdata_in[7:0];
      end
    end
  end

  // ****************************************
  // force reset request
  // ****************************************
  // only the background write path reaches the force reset bit
  // a one-cycle pulse: the flop reloads every cycle, so it drops once the background write is gone
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      reset_req_r <= 1'b0;
    end else begin
      reset_req_r <= bg_wr_byte && (bg_addr_in == `DBGBF_ADR_FORCE_RESET) &&
                     bg_wdata_in[`DBGBF_BIT_FORCE_RESET];
    end
  end
  assign mcu_reset_req_out = reset_req_r;

  // ****************************************
  // breakpoint compare
  // ****************************************
  // force requests a break at the next boundary; tag marks this fetch only
  wire bkpt_hit = bg_status_r[`DBGBF_BIT_BKPT_ENABLE] && cpu_fetch_in &&
                  (cpu_addr_in == bkpt_addr_r);
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      force_req_r <= 1'b0;
      tag_r <= 1'b0;
    end else begin
      force_req_r <= bkpt_hit && bg_status_r[`DBGBF_BIT_FORCE_TAG];
      tag_r <= bkpt_hit && !bg_status_r[`DBGBF_BIT_FORCE_TAG] && cpu_opcode_in;
    end
  end
  assign bkpt_force_req_out = force_req_r;
  assign bkpt_tag_out = tag_r;

  // ****************************************
  // last fetched opcode address
  // ****************************************
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      last_opcode_r <= `DBGBF_RST_WORD;
    end else if (cpu_fetch_in && cpu_opcode_in) begin
      last_opcode_r <= cpu_addr_in;
    end
  end

  // ****************************************
  // trace fifo
  // ****************************************
  // every unarmed low read reloads the tail, so the count pins at full;
  // an empty fifo is never reported, stale words simply read back
  dbgbf_trace_fifo u_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .push_in(trace_push_in && run_flag_r),
    .push_data_in(event_only_mode_in ? {8'h00, trace_data_in[7:0]} : trace_data_in),
    .advance_in(fifo_advance),
    .load_last_in(fifo_advance),
    .load_data_in(last_opcode_r),
    .head_out(fifo_head),
    .full_out(fifo_full_out),
    .empty_out()
  );

  // ****************************************
  // read data
  // ****************************************
  // cpu data registered one cycle after the strobe, holds until the next read
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      cpu_rdata_r <= `DBGBF_RST_BYTE;
    end else if (cpu_rd_in) begin
      cpu_rdata_r <= rd_byte(cpu_addr_in);
    end
  end

  // every command gets one acknowledge pulse, reads and writes alike
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      bg_ack_r <= 1'b0;
    end else begin
      bg_ack_r <= bg_cmd_valid_in;
    end
  end

  // host data stands until the next read command; write commands leave it
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      bg_rdata_r <= `DBGBF_RST_WORD;
    end else if (bg_rd_byte) begin
      bg_rdata_r <= {8'h00, rd_byte(bg_addr_in)};
    end else if (bg_rd_bkpt) begin
      bg_rdata_r <= bkpt_addr_r;
    end else if (bg_rd_stat) begin
      bg_rdata_r <= {8'h00, bg_status_r};
    end
  end
  assign cpu_rdata_out = cpu_rdata_r;
  assign bg_rdata_out = bg_rdata_r;
  assign bg_ack_out = bg_ack_r;
endmodule // dbgbf_debug_regs

/* File: pkg/dbgbf_map.vh */
`ifndef DBGBF_MAP_VH
`define DBGBF_MAP_VH
// ****************************************
// memory map, byte addresses
// ****************************************
`define DBGBF_ADR_FORCE_RESET 16'h1800
`define DBGBF_ADR_CMP_A_HIGH 16'h1810
`define DBGBF_ADR_CMP_A_LOW 16'h1811
`define DBGBF_ADR_CMP_B_HIGH 16'h1812
`define DBGBF_ADR_CMP_B_LOW 16'h1813
`define DBGBF_ADR_FIFO_HIGH 16'h1814
`define DBGBF_ADR_FIFO_LOW 16'h1815
`define DBGBF_ADR_RUN_CTRL 16'h1816
// ****************************************
// field positions
// ****************************************
`define DBGBF_BIT_FORCE_RESET 0
`define DBGBF_BIT_RUN_FLAG 6
`define DBGBF_BIT_BKPT_ENABLE 5
`define DBGBF_BIT_FORCE_TAG 4
// ****************************************
// reset values
// ****************************************
`define DBGBF_RST_BYTE 8'h00
`define DBGBF_RST_WORD 16'h0000
`define DBGBF_RST_BG_STATUS 8'h00
// ****************************************
// background command codes
// ****************************************
`define DBGBF_CMD_READ_BYTE 3'h0
`define DBGBF_CMD_WRITE_BYTE 3'h1
`define DBGBF_CMD_READ_BREAK 3'h2
`define DBGBF_CMD_WRITE_BREAK 3'h3
`define DBGBF_CMD_READ_STATUS 3'h4
`define DBGBF_CMD_WRITE_CONTROL 3'h5
// ****************************************
// trace fifo size
// ****************************************
`define DBGBF_FIFO_DEPTH 8
`define DBGBF_FIFO_CNT_W 4
`define DBGBF_FIFO_FULL_CNT 4'h8
`endif

/* File: rtl/dbgbf_trace_fifo.v */
`timescale 1ns/1ps
`include "dbgbf_map.vh"
module dbgbf_trace_fifo (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // fill side
  input wire push_in,
  input wire [15:0] push_data_in,
  // drain side
  input wire advance_in,
  input wire load_last_in,
  input wire [15:0] load_data_in,
  // state
  output wire [15:0] head_out,
  output wire full_out,
  output wire empty_out
);
  // ****************************************
  // storage
  // ****************************************
  reg [15:0] word_r [0:`DBGBF_FIFO_DEPTH-1];
  reg [`DBGBF_FIFO_CNT_W-1:0] count_r;
  integer i;

  assign head_out = word_r[0];
  assign full_out = (count_r == `DBGBF_FIFO_FULL_CNT);
  assign empty_out = (count_r == {`DBGBF_FIFO_CNT_W{1'b0}});

  // shift toward the head on advance; the tail slot takes the profiling word
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      count_r <= {`DBGBF_FIFO_CNT_W{1'b0}};
      for (i = 0; i < `DBGBF_FIFO_DEPTH; i = i + 1) begin
        word_r[i] <= `DBGBF_RST_WORD;
      end
    end else if (advance_in) begin
      for (i = 0; i < `DBGBF_FIFO_DEPTH - 1; i = i + 1) begin
        word_r[i] <= word_r[i+1];
      end
      word_r[`DBGBF_FIFO_DEPTH-1] <= load_last_in ? load_data_in : `DBGBF_RST_WORD;
      // a profiling load refills the tail, so seven reads later it reaches the head
      if (load_last_in) begin
        count_r <= `DBGBF_FIFO_FULL_CNT;
      end else if (!empty_out) begin
        count_r <= count_r - 1'b1;
      end
    end else if (push_in && !full_out) begin
      word_r[count_r[2:0]] <= push_data_in;
      count_r <= count_r + 1'b1;
    end
  end
endmodule // dbgbf_trace_fifo

/* File: verif/dbgbf_debug_regs_properties.sv */
`timescale 1ns/1ps
`include "dbgbf_map.vh"
// ****************************************
// port checker for the debug register block
// ****************************************
module dbgbf_regs_chk (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // cpu side
  input wire [15:0] cpu_addr_in,
  input wire cpu_rd_in,
  input wire cpu_wr_in,
  input wire [7:0] cpu_wdata_in,
  input wire [7:0] cpu_rdata_out,
  // background side
  input wire bg_cmd_valid_in,
  input wire [2:0] bg_cmd_in,
  input wire [15:0] bg_addr_in,
  input wire [15:0] bg_wdata_in,
  input wire bg_ack_out,
  // trace and results
  input wire event_only_mode_in,
  input wire run_done_in,
  input wire [15:0] cmp_a_value_out,
  input wire run_flag_out,
  input wire mcu_reset_req_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // background byte write aimed at the force reset byte
  wire fr_w = bg_cmd_valid_in && bg_cmd_in == `DBGBF_CMD_WRITE_BYTE &&
              bg_addr_in == `DBGBF_ADR_FORCE_RESET;
  wire fr_one = fr_w && bg_wdata_in[`DBGBF_BIT_FORCE_RESET];
  // only a background write of a one may pull the reset request
  reset_cause_a: assert property (mcu_reset_req_out |-> $past(fr_one))
    else $error("reset request without background write of one");
  reset_pulse_a: assert property (fr_one |=> mcu_reset_req_out)
    else $error("background force reset not honoured");
  bg_ack_a: assert property (bg_cmd_valid_in |=> bg_ack_out)
    else $error("background command not acknowledged");
  force_rd_a: assert property (cpu_rd_in && cpu_addr_in == 16'h1800 |=> cpu_rdata_out == 8'h00)
    else $error("force reset byte read not zero");
  evt_high_a: assert property (cpu_rd_in && cpu_addr_in == 16'h1814 && event_only_mode_in
    |=> cpu_rdata_out == 8'h00)
    else $error("fifo high byte not zero in event mode");
  cmp_lock_a: assert property (run_flag_out |=> $stable(cmp_a_value_out))
    else $error("comparator changed while running");
  cmp_write_a: assert property (!run_flag_out && cpu_wr_in && !bg_cmd_valid_in
    && cpu_addr_in == 16'h1810 |=> cmp_a_value_out[15:8] == $past(cpu_wdata_in))
    else $error("comparator high byte not joined on top");
  run_clear_a: assert property (run_done_in && !cpu_wr_in && !bg_cmd_valid_in
    |=> !run_flag_out)
    else $error("run flag survived run completion");
  rdata_hold_a: assert property (!cpu_rd_in |=> $stable(cpu_rdata_out))
    else $error("read data moved without a read");
endmodule // dbgbf_regs_chk
bind dbgbf_debug_regs dbgbf_regs_chk chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in),
  .cpu_addr_in(cpu_addr_in), .cpu_rd_in(cpu_rd_in), .cpu_wr_in(cpu_wr_in),
  .cpu_wdata_in(cpu_wdata_in), .cpu_rdata_out(cpu_rdata_out),
  .bg_cmd_valid_in(bg_cmd_valid_in), .bg_cmd_in(bg_cmd_in), .bg_addr_in(bg_addr_in),
  .bg_wdata_in(bg_wdata_in), .bg_ack_out(bg_ack_out),
  .event_only_mode_in(event_only_mode_in), .run_done_in(run_done_in),
  .cmp_a_value_out(cmp_a_value_out), .run_flag_out(run_flag_out),
  .mcu_reset_req_out(mcu_reset_req_out)
);

/* File: verif/dbgbf_bg_host.sv */
`timescale 1ns/1ps
// ****************************************
// serial background host model
// ****************************************
module dbgbf_bg_host (
  // clock
  input wire clk_in,
  // command toward the device
  output logic cmd_valid_out,
  output logic [2:0] cmd_out,
  output logic [15:0] addr_out,
  output logic [15:0] wdata_out,
  // answer from the device
  input wire [15:0] rdata_in,
  input wire ack_in
);
  // idle at time zero
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out = 3'h0;
    addr_out = 16'h0000;
    wdata_out = 16'h0000;
  end
  // one command, held until the taking edge; released address and data lines show inverse
  task send(input logic [2:0] c, input logic [15:0] a, input logic [15:0] d,
            output logic [15:0] rd, output bit ok);
    @(posedge clk_in);
    #1;
    cmd_valid_out = 1'b1;
    cmd_out = c;
    addr_out = a;
    wdata_out = d;
    @(posedge clk_in);
    #1;
    cmd_valid_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
    ok = ack_in;
    rd = rdata_in;
  endtask
endmodule // dbgbf_bg_host

/* File: verif/dbgbf_debug_regs_tb.sv */
`timescale 1ns/1ps
module dbgbf_debug_regs_tb;
  logic clk_in, rst_n_in, cpu_rd_in, cpu_wr_in, cpu_fetch_in, cpu_opcode_in;
  logic trace_push_in, event_only_mode_in, run_done_in, bg_cmd_valid_in, bg_ack_out;
  logic run_flag_out, fifo_full_out, bkpt_force_req_out, bkpt_tag_out, mcu_reset_req_out;
  logic [15:0] cpu_addr_in, trace_data_in, bg_addr_in, bg_wdata_in, bg_rdata_out;
  logic [15:0] cmp_a_value_out, cmp_b_value_out, r;
  logic [7:0] cpu_wdata_in, cpu_rdata_out;
  logic [2:0] bg_cmd_in;
  logic [31:0] seed;
  logic [15:0] w [16];
  int n_errors, checks_done, i;
  bit ok;
  dbgbf_debug_regs dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .cpu_addr_in(cpu_addr_in), .cpu_rd_in(cpu_rd_in), .cpu_wr_in(cpu_wr_in),
    .cpu_wdata_in(cpu_wdata_in), .cpu_rdata_out(cpu_rdata_out),
    .cpu_fetch_in(cpu_fetch_in), .cpu_opcode_in(cpu_opcode_in),
    .bg_cmd_valid_in(bg_cmd_valid_in), .bg_cmd_in(bg_cmd_in), .bg_addr_in(bg_addr_in),
    .bg_wdata_in(bg_wdata_in), .bg_rdata_out(bg_rdata_out), .bg_ack_out(bg_ack_out),
    .trace_push_in(trace_push_in), .trace_data_in(trace_data_in),
    .event_only_mode_in(event_only_mode_in), .run_done_in(run_done_in),
    .cmp_a_value_out(cmp_a_value_out), .cmp_b_value_out(cmp_b_value_out),
    .run_flag_out(run_flag_out), .fifo_full_out(fifo_full_out),
    .bkpt_force_req_out(bkpt_force_req_out), .bkpt_tag_out(bkpt_tag_out),
    .mcu_reset_req_out(mcu_reset_req_out)
  );
  dbgbf_bg_host host (
    .clk_in(clk_in),
    .cmd_valid_out(bg_cmd_valid_in),
    .cmd_out(bg_cmd_in),
    .addr_out(bg_addr_in),
    .wdata_out(bg_wdata_in),
    .rdata_in(bg_rdata_out),
    .ack_in(bg_ack_out)
  );
  // ****************************************
  // clock and helpers
  // ****************************************
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // comparator word as the block must present it
  function logic [15:0] cmp_word(input logic [7:0] h, input logic [7:0] l);
    return {h, l};
  endfunction
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // cpu access; an idle cycle follows so strobes never toggle twice at once
  task acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
    cpu_addr_in = a;
    cpu_wdata_in = d;
    cpu_rd_in = !wr;
    cpu_wr_in = wr;
    @(posedge clk_in);
    #1;
    cpu_rd_in = 1'b0;
    cpu_wr_in = 1'b0;
    @(posedge clk_in);
    #1;
  endtask
  task bg(input logic [2:0] c, input logic [15:0] a, input logic [15:0] d);
    host.send(c, a, d, r, ok);
    check(ok, 1'b1);
    if (!ok) give_verdict;
  endtask
  // fetch cycle; break outputs caught in the cycle after
  task fetch(input logic [15:0] a, input logic op);
    cpu_addr_in = a;
    cpu_fetch_in = 1'b1;
    cpu_opcode_in = op;
    @(posedge clk_in);
    #1;
    cpu_fetch_in = 1'b0;
    cpu_opcode_in = 1'b0;
    r = {14'h0, bkpt_force_req_out, bkpt_tag_out};
    @(posedge clk_in);
    #1;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {cpu_rd_in, cpu_wr_in, cpu_fetch_in, cpu_opcode_in} = 4'h0;
    {trace_push_in, event_only_mode_in, run_done_in, rst_n_in} = 4'h0;
    {cpu_addr_in, trace_data_in, cpu_wdata_in} = 40'h00_0000_0000;
    seed = 32'hf8b2;
    n_errors = 0;
    checks_done = 0;
    repeat (2) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    // comparator bytes: cleared, then joined and locked while running
    for (i = 0; i < 4; i++) begin
      acc(1'b0, 16'h1810 + i[15:0], 8'h00);
      check(cpu_rdata_out, 8'h00);
    end
    seed = lfsr(seed);
    for (i = 0; i < 4; i++) acc(1'b1, 16'h1810 + i[15:0], seed[8*i+:8]);
    check(cmp_a_value_out, cmp_word(seed[7:0], seed[15:8]));
    check(cmp_b_value_out, cmp_word(seed[23:16], seed[31:24]));
    acc(1'b1, 16'h1816, 8'h40);
    acc(1'b1, 16'h1811, ~seed[15:8]);
    check(cmp_a_value_out, cmp_word(seed[7:0], seed[15:8]));
    // fill the trace while running
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      w[i] = seed[15:0];
      trace_push_in = 1'b1;
      trace_data_in = w[i];
      @(posedge clk_in);
      #1;
    end
    trace_push_in = 1'b0;
    check(fifo_full_out, 1'b1);
    acc(1'b0, 16'h1815, 8'h00);
    check(cpu_rdata_out, w[0][7:0]);
    acc(1'b0, 16'h1814, 8'h00);
    check(cpu_rdata_out, w[0][15:8]);
    run_done_in = 1'b1;
    @(posedge clk_in);
    #1;
    run_done_in = 1'b0;
    check(run_flag_out, 1'b0);
    event_only_mode_in = 1'b1;
    acc(1'b0, 16'h1814, 8'h00);
    check(cpu_rdata_out, 8'h00);
    event_only_mode_in = 1'b0;
    acc(1'b1, 16'h1814, 8'hff);
    acc(1'b1, 16'h1815, 8'hff);
    check(run_flag_out, 1'b0);
    // drain high before low, high twice to show it does not shift
    for (i = 0; i < 24; i++) begin
      if (i >= 8) begin
        seed = lfsr(seed);
        w[i-8] = seed[15:0];
        fetch(w[i-8], 1'b1);
      end
      acc(1'b0, 16'h1814, 8'h00);
      acc(1'b0, 16'h1814, 8'h00);
      if (i < 8) check(cpu_rdata_out, w[i][15:8]);
      if (i >= 16) check(cpu_rdata_out, w[i-16][15:8]);
      acc(1'b0, 16'h1815, 8'h00);
      if (i < 8) check(cpu_rdata_out, w[i][7:0]);
      if (i >= 16) check(cpu_rdata_out, w[i-16][7:0]);
    end
    // breakpoint set up from the host before the code runs
    seed = lfsr(seed);
    bg(3'h3, 16'h0000, seed[15:0]);
    bg(3'h2, 16'h0000, 16'h0000);
    check(r, seed[15:0]);
    bg(3'h5, 16'h0000, 16'h0030);
    fetch(seed[15:0], 1'b0);
    check(r, 16'h0002);
    fetch(seed[15:0] + 16'h0001, 1'b0);
    check(r, 16'h0000);
    bg(3'h5, 16'h0000, 16'h0020);
    fetch(seed[15:0], 1'b1);
    check(r, 16'h0001);
    bg(3'h5, 16'h0000, 16'h0010);
    fetch(seed[15:0], 1'b1);
    check(r, 16'h0000);
    bg(3'h4, 16'h0000, 16'h0000);
    check(r[7:0], 8'h10);
    // background byte commands reach the mapped comparator bytes too
    bg(3'h1, 16'h1812, seed[15:0]);
    bg(3'h0, 16'h1812, 16'h0000);
    check(r, {8'h00, seed[7:0]});
    check(cmp_b_value_out[15:8], seed[7:0]);
    // force reset: cpu write ignored, reads zero, only a background one acts
    {cpu_addr_in, cpu_wdata_in, cpu_wr_in} = {16'h1800, 8'h01, 1'b1};
    @(posedge clk_in);
    #1;
    cpu_wr_in = 1'b0;
    check(mcu_reset_req_out, 1'b0);
    acc(1'b0, 16'h1800, 8'h00);
    check(cpu_rdata_out, 8'h00);
    bg(3'h1, 16'h1800, 16'h0000);
    check(mcu_reset_req_out, 1'b0);
    bg(3'h1, 16'h1800, 16'h0001);
    check(mcu_reset_req_out, 1'b1);
    rst_n_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    check(cmp_a_value_out, 16'h0000);
    give_verdict;
  end
endmodule // dbgbf_debug_regs_tb
